// ===== pkg/gpio_led_consts.svh
// constants for the multipurpose gpio / status light pins
// assumes a 100 MHz system clock; included by bare name
`ifndef GPIO_LED_CONSTS_SVH
`define GPIO_LED_CONSTS_SVH

// number of multipurpose pins
`define GPIO_PIN_COUNT   3
// light bit positions inside the light vector
`define LIGHT_SPEED_BIT  0
`define LIGHT_LINK_BIT   1
`define LIGHT_DUPLEX_BIT 2
// blink phase time in ms, as specified
`define LED_BLINK_MS     80
// system clock rate in kHz (100 MHz)
`define CLK_FREQ_KHZ     100000
// blink counter width, holds 80 ms of 100 MHz cycles
`define LED_CNT_W        24
// pin reset values: released, not driven
`define GPIO_OE_RESET    3'h0
`define GPIO_OUT_RESET   3'h0
// lights reset unlit (open-drain released)
`define LIGHT_RESET      3'h7

`endif

// ===== pkg/gpio_led_pkg.sv
// types for the multipurpose gpio / status light pins
// assumes the constants header is included by the design file
package gpio_led_pkg;

  // link-and-activity light sequencer states
  typedef enum logic [1:0] {
    LA_IDLE,  // no link, light unlit
    LA_ON,    // link up, light lit
    LA_OFF,   // activity blink, light unlit
    LA_HOLD   // lit for at least one blink time
  } la_state_t;

endpackage

// ===== hw/gpio_led_indicator_pins.sv
// three multipurpose pins: software gpio or open-drain status lights
// assumes link status inputs come from mac/phy logic on clk_i;
// pad inputs are asynchronous and are synchronised here
`timescale 1ns/1ps
`include "gpio_led_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - each pin: push-pull, open-drain or input
// - light-assigned pin drives open-drain only
// - speed light low at 100M, autoneg, unplugged
// - speed light high only at 10M
// - link light lit while link valid
// - activity blinks link light off 80 ms
// - then lit at least 80 ms, repeat
// - duplex light low in full duplex with link up, released without link
module gpio_led_indicator_pins #(
  parameter int unsigned BLINK_CYCLES = `LED_BLINK_MS * `CLK_FREQ_KHZ
) (
  input  wire logic       clk_i,          // system clock, 100 MHz
  input  wire logic       rst_b_i,        // async reset, active low
  input  wire logic       en_i,           // clock enable, freezes state when low
  input  wire logic [2:0] gpio_dir_out_i, // 1: pin is an output
  input  wire logic [2:0] gpio_od_i,      // 1: output is open-drain
  input  wire logic [2:0] gpio_out_i,     // gpio output value
  input  wire logic [2:0] light_sel_i,    // 1: pin carries its status light
  input  wire logic       link_up_i,      // valid link present
  input  wire logic       speed_100_i,    // link runs at 100 Mb/s
  input  wire logic       autoneg_busy_i, // auto-negotiation in progress
  input  wire logic       full_duplex_i,  // link is full duplex
  input  wire logic       activity_i,     // tx or rx activity seen
  input  wire logic [2:0] gpio_pin_i,     // pad levels, asynchronous
  output logic      [2:0] gpio_pin_o,     // pad output value
  output logic      [2:0] gpio_pin_oe_o,  // pad output enable, high drives
  output logic      [2:0] gpio_in_o       // synchronised pad levels
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  localparam logic [`LED_CNT_W-1:0] BlinkLast = `LED_CNT_W'(BLINK_CYCLES - 1);

  gpio_led_pkg::la_state_t la_q;       // link light sequencer state
  gpio_led_pkg::la_state_t la_d;
  logic [`LED_CNT_W-1:0]   cnt_q;      // blink phase down counter
  logic [`LED_CNT_W-1:0]   cnt_d;
  logic                    act_pend_q; // activity seen, blink owed
  logic [2:0]              light_n_q;  // active-low light levels
  logic [2:0]              sync1_q;    // first synchroniser stage
  logic                    speed_10;   // link up at 10 Mb/s, settled

  assign speed_10 = link_up_i && !speed_100_i && !autoneg_busy_i;

  ////////////////////////////////////////////////////////////////////////////
  // pad input synchroniser; first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q   <= 3'h0;
      gpio_in_o <= 3'h0;
    end else if (en_i) begin
      sync1_q   <= gpio_pin_i;
      gpio_in_o <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending activity flag; a new event beats the clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_pend_q <= 1'b0;
    end else if (en_i) begin
      if (activity_i && link_up_i) begin
        act_pend_q <= 1'b1;
      end else if (!link_up_i) begin
        act_pend_q <= 1'b0; // stale activity dies with the link
      end else if (la_q == gpio_led_pkg::LA_ON && act_pend_q) begin
        act_pend_q <= 1'b0; // blink taken
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link light sequencer: on, off-blink, minimum on-hold
  always_comb begin
    la_d  = la_q;
    cnt_d = cnt_q;
    if (!link_up_i) begin
      la_d  = gpio_led_pkg::LA_IDLE; // link loss wins over any phase
      cnt_d = '0;
    end else begin
      case (la_q)
        gpio_led_pkg::LA_IDLE: begin
          la_d = gpio_led_pkg::LA_ON;
        end
        gpio_led_pkg::LA_ON: begin
          if (act_pend_q) begin
            la_d  = gpio_led_pkg::LA_OFF;
            cnt_d = BlinkLast;
          end
        end
        gpio_led_pkg::LA_OFF: begin
          if (cnt_q == '0) begin
            la_d  = gpio_led_pkg::LA_HOLD;
            cnt_d = BlinkLast;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        gpio_led_pkg::LA_HOLD: begin
          if (cnt_q == '0) begin
            la_d = gpio_led_pkg::LA_ON;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        default: begin
          la_d = gpio_led_pkg::LA_IDLE;
        end
      endcase
    end
  end

  // sequencer state and counter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      la_q  <= gpio_led_pkg::LA_IDLE;
      cnt_q <= '0;
    end else if (en_i) begin
      la_q  <= la_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // light levels, registered so the pad stage sees clean values
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      light_n_q <= `LIGHT_RESET;
    end else if (en_i) begin
      light_n_q[`LIGHT_SPEED_BIT] <= speed_10;
      // lit (low) only while on or holding
      light_n_q[`LIGHT_LINK_BIT] <= !(la_d == gpio_led_pkg::LA_ON ||
                                      la_d == gpio_led_pkg::LA_HOLD);
      // full duplex has no meaning without a link
      light_n_q[`LIGHT_DUPLEX_BIT] <= !(link_up_i && full_duplex_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin driver: light override, else configured gpio
  for (genvar k = 0; k < `GPIO_PIN_COUNT; k++) begin : g_pin
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        gpio_pin_o[k]    <= 1'b0;
        gpio_pin_oe_o[k] <= 1'b0;
      end else if (en_i) begin
        if (light_sel_i[k]) begin
          // open-drain whatever the push-pull setting says
          gpio_pin_o[k]    <= 1'b0;
          gpio_pin_oe_o[k] <= !light_n_q[k];
        end else if (!gpio_dir_out_i[k]) begin
          gpio_pin_o[k]    <= 1'b0;           // input: released
          gpio_pin_oe_o[k] <= 1'b0;
        end else if (gpio_od_i[k]) begin
          gpio_pin_o[k]    <= 1'b0;
          gpio_pin_oe_o[k] <= !gpio_out_i[k];
        end else begin
          gpio_pin_o[k]    <= gpio_out_i[k];
          gpio_pin_oe_o[k] <= 1'b1;
        end
      end
    end

    // checks on each pin driver
    sequence s_pp_cfg;
      en_i && !light_sel_i[k] && gpio_dir_out_i[k] && !gpio_od_i[k];
    endsequence
    property p_push_pull;
      @(posedge clk_i) disable iff (!rst_b_i)
        s_pp_cfg |=> gpio_pin_oe_o[k] && gpio_pin_o[k] == $past(gpio_out_i[k]);
    endproperty
    a_push_pull: assert property (p_push_pull)
      else $error("push-pull pin not driving its value");

    property p_input_released;
      @(posedge clk_i) disable iff (!rst_b_i)
        (en_i && !light_sel_i[k] && !gpio_dir_out_i[k]) |=> !gpio_pin_oe_o[k];
    endproperty
    a_input_released: assert property (p_input_released)
      else $error("input pin is being driven");

    property p_light_od;
      @(posedge clk_i) disable iff (!rst_b_i)
        (en_i && light_sel_i[k]) |=> !gpio_pin_o[k] &&
          gpio_pin_oe_o[k] == !$past(light_n_q[k]);
    endproperty
    a_light_od: assert property (p_light_od)
      else $error("light pin not open-drain or not following light");
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and light checks
  property p_speed_low;
    @(posedge clk_i) disable iff (!rst_b_i)
      (en_i && (!link_up_i || speed_100_i || autoneg_busy_i))
        |=> !light_n_q[`LIGHT_SPEED_BIT];
  endproperty
  a_speed_low: assert property (p_speed_low)
    else $error("speed light released outside 10M operation");

  property p_speed_high;
    @(posedge clk_i) disable iff (!rst_b_i)
      (en_i && speed_10) |=> light_n_q[`LIGHT_SPEED_BIT];
  endproperty
  a_speed_high: assert property (p_speed_high)
    else $error("speed light low during 10M operation");

  property p_link_lit;
    @(posedge clk_i) disable iff (!rst_b_i)
      (en_i && link_up_i && la_q == gpio_led_pkg::LA_ON && !act_pend_q)
        ##1 en_i |=> !light_n_q[`LIGHT_LINK_BIT] ||
          la_q != gpio_led_pkg::LA_ON;
  endproperty
  a_link_lit: assert property (p_link_lit)
    else $error("link light unlit with link idle and valid");

  sequence s_blink_start;
    en_i && link_up_i && la_q == gpio_led_pkg::LA_ON && act_pend_q;
  endsequence
  property p_blink_off;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_blink_start |=> la_q == gpio_led_pkg::LA_OFF && cnt_q == BlinkLast &&
        light_n_q[`LIGHT_LINK_BIT];
  endproperty
  a_blink_off: assert property (p_blink_off)
    else $error("activity did not start a full off phase");

  property p_off_holds;
    @(posedge clk_i) disable iff (!rst_b_i)
      (en_i && link_up_i && la_q == gpio_led_pkg::LA_OFF && cnt_q != '0)
        |=> la_q == gpio_led_pkg::LA_OFF && light_n_q[`LIGHT_LINK_BIT];
  endproperty
  a_off_holds: assert property (p_off_holds)
    else $error("off phase ended early");

  property p_hold_min;
    @(posedge clk_i) disable iff (!rst_b_i)
      (en_i && link_up_i && la_q == gpio_led_pkg::LA_HOLD && cnt_q != '0)
        |=> la_q == gpio_led_pkg::LA_HOLD && !light_n_q[`LIGHT_LINK_BIT];
  endproperty
  a_hold_min: assert property (p_hold_min)
    else $error("lit hold phase ended early");

  property p_duplex;
    @(posedge clk_i) disable iff (!rst_b_i)
      en_i |=> light_n_q[`LIGHT_DUPLEX_BIT] ==
        !($past(link_up_i) && $past(full_duplex_i));
  endproperty
  a_duplex: assert property (p_duplex)
    else $error("duplex light wrong");

  property p_override;
    @(posedge clk_i) disable iff (!rst_b_i)
      (en_i && light_sel_i[`LIGHT_LINK_BIT] && gpio_dir_out_i[`LIGHT_LINK_BIT] &&
        !gpio_od_i[`LIGHT_LINK_BIT] && light_n_q[`LIGHT_LINK_BIT])
        |=> !gpio_pin_oe_o[`LIGHT_LINK_BIT];
  endproperty
  a_override: assert property (p_override)
    else $error("gpio value leaked onto a light pin");

endmodule

// ===== tb/gpio_pad_board.sv
// board side of the three multipurpose pads: pull-ups, lights, signals
// assumes oe high means the block drives the pad with pin_o
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module gpio_pad_board (
  input  wire logic [2:0] pin_o_i,   // pad value from the block
  input  wire logic [2:0] oe_i,      // pad enable from the block
  input  wire logic [2:0] ext_en_i,  // board signal drives a released pad
  input  wire logic [2:0] ext_val_i, // board signal level
  output logic      [2:0] pad_o,     // resolved pad level
  output logic      [2:0] lit_o      // light glows while pad is low
);
  // a released pad with no board driver floats up to the pull-up level;
  // the board only drives a pad the block has let go, so no contention
  assign pad_o = (oe_i & pin_o_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i);
  // open-drain light to the supply: lit when pulled low
  assign lit_o = ~pad_o;
endmodule

// ===== tb/gpio_led_indicator_pins_tb.sv
// self-checking bench for the gpio / status light pins
// assumes a short blink count and a board model with pull-ups
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module gpio_led_indicator_pins_tb;
  localparam int B = 4;  // short blink time keeps the run small
  logic clk_i = 0, rst_b_i = 0, en_i = 0, link_up_i = 0, speed_100_i = 0;
  logic autoneg_busy_i = 0, full_duplex_i = 0, activity_i = 0;
  logic [2:0] gpio_dir_out_i = 0, gpio_od_i = 0, gpio_out_i = 0, light_sel_i = 0;
  logic [2:0] ext_en = 0, ext_val = 0, pad, gpio_pin_o, gpio_pin_oe_o, gpio_in_o;
  logic [2:0] m_po, m_oe, m_lt, m_s1, m_s2;  // model registers
  logic [15:0] r = 16'h0038, q;              // random words, seed 56
  int errors = 0, cmp_count = 0, st, cnt, sv;
  bit pend, a;

  always #5 clk_i = ~clk_i;

  gpio_led_indicator_pins #(.BLINK_CYCLES(B)) gpio_led_indicator_pins_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(en_i), .gpio_dir_out_i(gpio_dir_out_i),
    .gpio_od_i(gpio_od_i), .gpio_out_i(gpio_out_i), .light_sel_i(light_sel_i),
    .link_up_i(link_up_i), .speed_100_i(speed_100_i), .autoneg_busy_i(autoneg_busy_i),
    .full_duplex_i(full_duplex_i), .activity_i(activity_i), .gpio_pin_i(pad),
    .gpio_pin_o(gpio_pin_o), .gpio_pin_oe_o(gpio_pin_oe_o), .gpio_in_o(gpio_in_o));
  gpio_pad_board gpio_pad_board_i (.pin_o_i(gpio_pin_o), .oe_i(gpio_pin_oe_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad), .lit_o());

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reference model, updated on every enabled edge from pre-edge values
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      m_po = 3'h0;
      m_oe = 3'h0;
      m_lt = 3'h7;  // lights unlit
      st   = 0;
      cnt  = 0;
      pend = 0;
      sv   = 0;
    end else if (en_i) begin
      for (int k = 0; k < 3; k++) begin
        if (light_sel_i[k]) begin  // light owns the pin, open-drain only
          m_oe[k] = ~m_lt[k];
          m_po[k] = 1'b0;
        end else if (gpio_dir_out_i[k]) begin
          m_oe[k] = gpio_od_i[k] ? ~gpio_out_i[k] : 1'b1;
          m_po[k] = gpio_od_i[k] ? 1'b0 : gpio_out_i[k];
        end else begin  // input: released
          m_oe[k] = 1'b0;
          m_po[k] = 1'b0;
        end
      end
      // two-stage pad sampling
      m_s2 = m_s1;
      m_s1 = pad;
      if (sv < 2) begin
        sv++;
      end
      a = activity_i & link_up_i;
      if (!link_up_i) begin  // link loss aborts a blink
        st   = 0;
        pend = 0;
      end else begin
        case (st)
          0: st = 1;
          1: begin
            if (pend) begin
              st   = 2;
              cnt  = B - 1;
              pend = 0;
            end
          end
          2: begin
            if (cnt == 0) begin
              st  = 3;
              cnt = B - 1;
            end else begin
              cnt--;
            end
          end
          default: begin
            if (cnt == 0) begin
              st = 1;
            end else begin
              cnt--;
            end
          end
        endcase
      end
      if (a) begin  // a new sighting beats the clear
        pend = 1;
      end
      m_lt[0] = link_up_i & ~speed_100_i & ~autoneg_busy_i;
      m_lt[1] = (st == 0) || (st == 2);
      m_lt[2] = ~(link_up_i & full_duplex_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare where the outputs have settled
  always @(negedge clk_i) begin
    chk(gpio_pin_o, m_po);
    chk(gpio_pin_oe_o, m_oe);
    if (sv >= 2) chk(gpio_in_o, m_s2);
  end

  // one random cycle; link flips rarely so blinks run to completion
  task automatic stim;
    @(posedge clk_i);
    repeat (16) r = lfsr(r);
    q = r;
    repeat (16) q = lfsr(q);
    gpio_dir_out_i <= r[2:0];
    gpio_od_i      <= r[5:3];
    gpio_out_i     <= r[8:6];
    if (q[15:14] == 0) light_sel_i <= r[11:9];  // keep lights on pins a while
    speed_100_i    <= r[12];
    autoneg_busy_i <= r[13] & r[14];
    full_duplex_i  <= r[15];
    activity_i     <= (q[2:0] == 0);
    en_i           <= (q[7:4] != 0);  // occasional frozen cycle
    if (q[15:8] == 0) link_up_i <= ~link_up_i;
    ext_en         <= q[13:11];
    ext_val        <= q[12:10];
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, random run, reset in mid-run, random run
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1;
    repeat (3000) stim();
    @(posedge clk_i);
    rst_b_i <= 0;
    // frozen across the release edge: the flops are still held there,
    // so an enabled cycle at that edge would promise an update that never comes
    en_i    <= 0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1;
    repeat (1000) stim();
    end_of_test();
  end
endmodule
